// ### include/ldm_pkg.sv
// package of constants and types for the lcd display mode control block
package ldm_pkg;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] DISP_CTRL_OFF = 8'h00;
   localparam logic [7:0] DBL_POS_OFF = 8'h04;
   localparam logic [7:0] DRIVE_OFF = 8'h08;
   localparam logic [7:0] POWER_OFF = 8'h0c;
   localparam logic [7:0] STATUS_OFF = 8'h10;
   localparam logic [7:0] RASTER_OFF = 8'h14;
   // ==========================================
   // display control bit positions
   localparam int DHE_BIT = 0;
   localparam int REV_BIT = 1;
   localparam int CEN_BIT = 2;
   localparam int DON_BIT = 3;
   // power control bit positions
   localparam int SLP_BIT = 0;
   localparam int STB_BIT = 1;
   localparam int OSC_BIT = 8;
   localparam int AP_LSB = 4;
   // drive register field positions
   localparam int DUTY_LSB = 0;
   localparam int BIAS_LSB = 4;
   localparam int BOOST_LSB = 8;
   localparam int CT_LSB = 16;
   // double-height position field positions
   localparam int DS_LSB = 0;
   localparam int DE_LSB = 8;
   // ==========================================
   // reset values
   localparam logic [3:0] DUTY_RST = 4'he;
   localparam logic [2:0] BIAS_RST = 3'h0;
   localparam logic [1:0] BOOST_RST = 2'h2;
   localparam logic [5:0] CT_RST = 6'h20;
   localparam logic [1:0] AP_RST = 2'h0;
   // duty, bias, boost and amp power codes
   localparam logic [3:0] DUTY_120 = 4'he;
   localparam logic [3:0] DUTY_16 = 4'h1;
   localparam logic [2:0] BIAS_11 = 3'h0;
   localparam logic [2:0] BIAS_5 = 3'h6;
   localparam logic [1:0] BOOST_X6 = 2'h2;
   localparam logic [1:0] BOOST_X2 = 2'h0;
   localparam logic [1:0] AP_OFF = 2'h0;
   // ==========================================
   // timing and response codes
   localparam int CLK_HZ = 100_000_000;
   localparam int FRAME_HZ = 68;
   localparam int SCREEN_ROWS = 128;
   localparam int ROW_CYC = CLK_HZ / (FRAME_HZ * 120);
   localparam int OSC_STABLE_US = 1000;
   localparam int OSC_STABLE_CYC = OSC_STABLE_US * (CLK_HZ / 1_000_000);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================
   // types
   typedef enum logic [2:0] {
      LDM_RUN = 3'b001,
      LDM_SLEEP = 3'b010,
      LDM_STANDBY = 3'b100
   } ldm_mode_e;
   typedef struct packed {
      logic [6:0] com_row;
      logic [6:0] src_row;
      logic com_select;
      logic reverse;
      logic drive_off;
   } ldm_scan_s;
endpackage

// ### verilog/ldm_ctrl.sv
// lcd display mode control with axi4-lite register slave
`timescale 1ns/1ns
module ldm_ctrl
   import ldm_pkg::*;
#(
   parameter int OSC_WAIT = OSC_STABLE_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // scan to segment and common drivers
   output ldm_scan_s scan_out,
   output logic segment_output_gnd,
   output logic common_output_gnd,
   // analog drive settings
   output logic [3:0] duty_ratio_sel,
   output logic [2:0] bias_sel,
   output logic [1:0] boost_factor_sel,
   output logic [5:0] contrast_adjust,
   output logic lcd_power_on,
   output logic osc_run
);
   // ==========================================
   // registers
   logic [3:0] disp_reg; // dhe, reverse, centering, display on
   logic [6:0] ds_reg; // double start row
   logic [6:0] de_reg; // double end row
   logic [3:0] duty_reg;
   logic [2:0] bias_reg;
   logic [1:0] boost_reg;
   logic [5:0] ct_reg;
   logic [1:0] ap_reg;
   logic sleep_request;
   logic standby_request;
   logic osc_on_reg; // oscillator running
   logic [31:0] osc_cnt_reg; // stabilisation count
   ldm_mode_e mode_reg;
   ldm_mode_e mode_next;
   // write channel holding
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   // scan timing
   logic [31:0] row_div_reg;
   logic [6:0] line_reg; // common line counter
   ldm_scan_s scan_reg;

   // ==========================================
   // write path
   wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire wr_disp = awaddr_reg == DISP_CTRL_OFF;
   wire wr_pos = awaddr_reg == DBL_POS_OFF;
   wire wr_drv = awaddr_reg == DRIVE_OFF;
   wire wr_pwr = awaddr_reg == POWER_OFF;
   wire wr_known = wr_disp || wr_pos || wr_drv || wr_pwr;
   wire in_standby = mode_reg == LDM_STANDBY;
   // in standby only the power register may be written (oscillator start, standby clear)
   wire wr_allow = !in_standby || wr_pwr;
   wire wr_en = wr_go && wr_known && wr_allow;
   wire osc_start = wr_go && wr_pwr && wstrb_reg[1] && wdata_reg[OSC_BIT];
   // standby may only clear once oscillator is stable
   wire osc_ready = osc_on_reg && osc_cnt_reg >= OSC_WAIT;

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready = !w_held_reg;

   // capture write address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_reg <= 1'b0;
      end
   end

   // capture write data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_reg <= 1'b0;
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_known && wr_allow) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // display control and position registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_reg <= 4'h0;
         ds_reg <= 7'h00;
         de_reg <= 7'h00;
      end else if (wr_en && wr_disp && wstrb_reg[0]) begin
         disp_reg <= wdata_reg[3:0];
      end else if (wr_en && wr_pos) begin
         if (wstrb_reg[0]) ds_reg <= wdata_reg[DS_LSB +: 7];
         if (wstrb_reg[1]) de_reg <= wdata_reg[DE_LSB +: 7];
      end
   end

   // drive settings: duty, bias, boost, contrast
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         duty_reg <= DUTY_RST;
         bias_reg <= BIAS_RST;
         boost_reg <= BOOST_RST;
         ct_reg <= CT_RST;
      end else if (wr_en && wr_drv) begin
         if (wstrb_reg[0]) duty_reg <= wdata_reg[DUTY_LSB +: 4];
         if (wstrb_reg[0]) bias_reg <= wdata_reg[BIAS_LSB +: 3];
         if (wstrb_reg[1]) boost_reg <= wdata_reg[BOOST_LSB +: 2];
         if (wstrb_reg[2]) ct_reg <= wdata_reg[CT_LSB +: 6];
      end
   end

   // power control; in standby only a standby clear is taken here, once the oscillator is stable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_request <= 1'b0;
         standby_request <= 1'b0;
         ap_reg <= AP_RST;
      end else if (wr_go && wr_pwr && wstrb_reg[0]) begin
         if (!in_standby) begin
            sleep_request <= wdata_reg[SLP_BIT];
            standby_request <= wdata_reg[STB_BIT];
            ap_reg <= wdata_reg[AP_LSB +: 2];
         end else if (!wdata_reg[STB_BIT] && osc_ready) begin
            standby_request <= 1'b0;
         end
      end
   end

   // oscillator: stops in standby, restarted by start instruction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_on_reg <= 1'b1;
         osc_cnt_reg <= 32'h0000_0000;
      end else if (osc_start && !osc_on_reg) begin
         osc_on_reg <= 1'b1;
         osc_cnt_reg <= 32'h0000_0000;
      end else if (mode_next == LDM_STANDBY && !in_standby) begin
         osc_on_reg <= 1'b0;
         osc_cnt_reg <= 32'h0000_0000;
      end else if (osc_on_reg && !osc_ready) begin
         osc_cnt_reg <= osc_cnt_reg + 32'h0000_0001;
      end
   end

   // ==========================================
   // power mode state
   always_comb begin
      if (standby_request) begin
         mode_next = LDM_STANDBY;
      end else if (sleep_request) begin
         mode_next = LDM_SLEEP;
      end else begin
         mode_next = LDM_RUN;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) mode_reg <= LDM_RUN;
      else mode_reg <= mode_next;
   end

   // ==========================================
   // read path
   wire [31:0] rd_data =
      (s_axi_araddr == DISP_CTRL_OFF) ? {28'h0, disp_reg} :
      (s_axi_araddr == DBL_POS_OFF) ? {17'h0, de_reg, 1'b0, ds_reg} :
      (s_axi_araddr == DRIVE_OFF) ?
         {10'h0, ct_reg, 6'h0, boost_reg, 1'b0, bias_reg, duty_reg} :
      (s_axi_araddr == POWER_OFF) ?
         {23'h0, osc_on_reg, 2'h0, ap_reg, 2'h0, standby_request,
          sleep_request} :
      (s_axi_araddr == STATUS_OFF) ?
         {28'h0, osc_ready, mode_reg} :
      (s_axi_araddr == RASTER_OFF) ? {25'h0, line_reg} : 32'h0000_0000;
   wire rd_known = s_axi_araddr == DISP_CTRL_OFF
      || s_axi_araddr == DBL_POS_OFF || s_axi_araddr == DRIVE_OFF
      || s_axi_araddr == POWER_OFF || s_axi_araddr == STATUS_OFF
      || s_axi_araddr == RASTER_OFF;
   assign s_axi_arready = !s_axi_rvalid;

   // read data register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================
   // scan generation
   wire running = mode_reg == LDM_RUN;
   wire partial = duty_reg == DUTY_16;
   // lines per frame follow the duty; row time stretches to hold 68 Hz
   wire [6:0] frame_lines = partial ? 7'd16 : 7'd120;
   wire [31:0] row_len = partial ? 32'(ROW_CYC * 120 / 16) : 32'(ROW_CYC);
   wire row_tick = row_div_reg >= row_len - 32'd1;

   // row timer and common line counter, halted when not running
   always_ff @(posedge aclk) begin
      if (!aresetn || !running) begin
         row_div_reg <= 32'h0000_0000;
         line_reg <= 7'h00;
      end else if (row_tick) begin
         row_div_reg <= 32'h0000_0000;
         line_reg <= (line_reg >= frame_lines - 7'd1) ? 7'h00 :
            line_reg + 7'd1;
      end else begin
         row_div_reg <= row_div_reg + 32'h0000_0001;
      end
   end

   // partial area sits at top, or is centred on the 120 commons
   wire [6:0] com_base = disp_reg[CEN_BIT] ? 7'd52 : 7'd0;
   wire [6:0] com_now = line_reg + com_base;
   // doubled area on screen rows, after the centering offset
   wire in_dbl = disp_reg[DHE_BIT] && com_now >= ds_reg
      && com_now <= de_reg;
   // two commons per source row inside the area
   wire [6:0] dbl_src = ds_reg + 7'((com_now - ds_reg) >> 1);
   wire [6:0] src_now = in_dbl ? dbl_src : com_now;

   // scan output register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_reg <= '0;
      end else begin
         scan_reg.com_row <= com_now;
         scan_reg.src_row <= src_now;
         scan_reg.com_select <= running && disp_reg[DON_BIT];
         scan_reg.reverse <= disp_reg[REV_BIT];
         scan_reg.drive_off <= !running;
      end
   end

   assign scan_out = scan_reg;
   assign segment_output_gnd = scan_reg.drive_off;
   assign common_output_gnd = scan_reg.drive_off;
   assign duty_ratio_sel = duty_reg;
   assign bias_sel = bias_reg;
   assign boost_factor_sel = boost_reg;
   assign contrast_adjust = ct_reg;
   assign lcd_power_on = running || ap_reg != AP_OFF;
   assign osc_run = osc_on_reg;

   // ==========================================
   // assertions
   sleep_ground_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_reg != LDM_RUN |=> segment_output_gnd && common_output_gnd)
      else $error("outputs not grounded when halted");
   standby_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_standby && !$past(osc_start) && $past(in_standby) |-> !osc_on_reg
      || $past(osc_on_reg))
      else $error("oscillator ran in standby");
   amp_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !running && ap_reg == AP_OFF |-> !lcd_power_on)
      else $error("drive power on with amp off");
   standby_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_standby && wr_go && !wr_pwr |=> $stable(disp_reg)
      && s_axi_bresp == RESP_SLVERR)
      else $error("write taken in standby");
   dbl_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_dbl |-> com_now - src_now == src_now - ds_reg
      || com_now - src_now == src_now - ds_reg + 7'd1)
      else $error("doubled row mapping wrong");
   reverse_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> scan_reg.reverse == $past(disp_reg[REV_BIT]))
      else $error("reverse not applied");
   centre_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
      disp_reg[CEN_BIT] |-> com_now == line_reg + 7'd52)
      else $error("centering offset wrong");
   halt_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !running |=> line_reg == 7'h00)
      else $error("scan ran while halted");
   lines_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
      running && row_tick |=> line_reg < $past(frame_lines))
      else $error("partial scan too long");
   cov_sleep_c: cover property (@(posedge aclk) mode_reg == LDM_SLEEP);
   cov_standby_c: cover property (@(posedge aclk)
      in_standby ##1 mode_reg == LDM_RUN);
   cov_dbl_c: cover property (@(posedge aclk) in_dbl && running);
endmodule

// ### bench/ldm_panel_model.sv
// panel side model that watches the scan and the common ground output
`timescale 1ns/1ns
module ldm_panel_model
   import ldm_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // scan from the block
   input wire ldm_scan_s scan_out,
   input wire logic segment_output_gnd,
   input wire logic common_output_gnd,
   // observations
   output logic [15:0] row_count,
   output logic [6:0] last_com,
   output logic [6:0] last_src,
   output logic gnd_drive_seen
);
   // ==========================================
   // row tracking
   logic [6:0] prev_com; // common row of last cycle
   // log each new common row with its source row
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         row_count <= 16'h0000;
         prev_com <= 7'h00;
         last_com <= 7'h00;
         last_src <= 7'h00;
      end else if (scan_out.com_row != prev_com) begin
         row_count <= row_count + 16'h0001;
         prev_com <= scan_out.com_row;
         last_com <= scan_out.com_row;
         last_src <= scan_out.src_row;
      end
   end
   // ==========================================
   // grounded electrodes must not see a selected common
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gnd_drive_seen <= 1'b0;
      end else if (common_output_gnd && scan_out.com_select) begin
         gnd_drive_seen <= 1'b1;
      end
   end
endmodule

// ### bench/lcd_display_mode_control_tb.sv
// self-checking bench for the display mode control block
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module lcd_display_mode_control_tb;
   import ldm_pkg::*;
   // ==========================================
   // signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   ldm_scan_s scan_out;
   logic seg_gnd, com_gnd, power_on, osc_run;
   logic [3:0] duty;
   logic [2:0] bias;
   logic [1:0] boost;
   logic [5:0] ct;
   logic [15:0] row_count;
   logic [6:0] last_com, last_src;
   logic gnd_drive_seen;
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [31:0] dv;
   // ==========================================
   // design and panel
   ldm_ctrl #(.OSC_WAIT(10)) u_ldm_ctrl (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .scan_out(scan_out), .segment_output_gnd(seg_gnd),
      .common_output_gnd(com_gnd), .duty_ratio_sel(duty), .bias_sel(bias),
      .boost_factor_sel(boost), .contrast_adjust(ct),
      .lcd_power_on(power_on), .osc_run(osc_run));
   ldm_panel_model u_ldm_panel_model (.aclk(aclk), .aresetn(aresetn),
      .scan_out(scan_out), .segment_output_gnd(seg_gnd),
      .common_output_gnd(com_gnd), .row_count(row_count),
      .last_com(last_com), .last_src(last_src),
      .gnd_drive_seen(gnd_drive_seen));
   // ==========================================
   // clock and hang guard
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++; // run took too long
         final_report();
      end
   end
   // ==========================================
   // verdict
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // axi4-lite master cycles
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_d, w_d;
      aw_d = 0;
      w_d = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (1'b1) begin
         @(posedge aclk);
         if (!aw_d && awready === 1'b1) begin
            aw_d = 1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready === 1'b1) begin
            w_d = 1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) break;
      end
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      bit a_d;
      a_d = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (1'b1) begin
         @(posedge aclk);
         if (!a_d && arready === 1'b1) begin
            a_d = 1;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) break;
      end
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // source row expected for a common row, zero based
   function automatic logic [6:0] exp_src(input logic [6:0] k,
      input logic [6:0] ds, input logic [6:0] de);
      if (k >= ds && k <= de) return ds + ((k - ds) >> 1);
      return k;
   endfunction
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(477));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values of the drive settings
      `CHK(duty, DUTY_120)
      `CHK(bias, BIAS_11)
      `CHK(boost, BOOST_X6)
      `CHK(ct, CT_RST)
      // odd span, start not above end, doubled with reversal
      axi_wr(DBL_POS_OFF, 32'h0000_0200);
      axi_wr(DISP_CTRL_OFF, 32'h0000_000b);
      repeat (3) @(posedge aclk);
      `CHK(scan_out.reverse, 1'b1)
      `CHK(scan_out.com_select, 1'b1)
      for (int i = 0; i < 4; i++) begin
         int n;
         logic [15:0] c0;
         n = 0;
         c0 = row_count;
         while (row_count == c0) begin
            @(posedge aclk);
            n++;
         end
         if (i > 0) `CHK(n, ROW_CYC)
         `CHK(last_src, exp_src(last_com, 7'h00, 7'h02))
      end
      // partial drive codes with random contrast, display off first
      axi_wr(DISP_CTRL_OFF, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         dv = (32'(DUTY_16) << DUTY_LSB) | (32'(BIAS_5) << BIAS_LSB) |
            (32'(BOOST_X2) << BOOST_LSB) | ($urandom_range(63) << CT_LSB);
         axi_wr(DRIVE_OFF, dv);
         `CHK(resp, RESP_OKAY)
         axi_rd(DRIVE_OFF);
         `CHK(rd[21:16], dv[21:16])
         `CHK(ct, dv[21:16])
         `CHK(duty, DUTY_16)
         `CHK(bias, BIAS_5)
         `CHK(boost, BOOST_X2)
      end
      // centred partial area, display still off
      axi_wr(DISP_CTRL_OFF, 32'h0000_0004);
      axi_rd(RASTER_OFF);
      repeat (2) @(posedge aclk);
      `CHK(scan_out.com_row, rd[6:0] + 7'((120 - 16) / 2))
      `CHK(scan_out.com_select, 1'b0)
      // unmapped address answers with an error and zero data
      axi_rd(8'h3c);
      `CHK(resp, RESP_SLVERR)
      `CHK(rd, 32'h0)
      // sleep with amp power off
      axi_wr(POWER_OFF, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      `CHK({seg_gnd, com_gnd, osc_run}, 3'b111)
      `CHK(power_on, 1'b0)
      axi_rd(STATUS_OFF);
      `CHK(rd[2:0], 3'(LDM_SLEEP))
      axi_wr(POWER_OFF, 32'h0000_0010);
      // standby with amp power on; an amp-off write in standby leaves it on
      axi_wr(POWER_OFF, 32'h0000_0012);
      repeat (2) @(posedge aclk);
      `CHK({seg_gnd, com_gnd, osc_run, power_on}, 4'b1101)
      axi_wr(POWER_OFF, 32'h0000_0002);
      repeat (2) @(posedge aclk);
      `CHK(power_on, 1'b1)
      // writes refused in standby, early clear ignored
      axi_wr(DRIVE_OFF, 32'h0000_0000);
      `CHK(resp, RESP_SLVERR)
      `CHK(duty, DUTY_16)
      axi_wr(POWER_OFF, 32'h0000_0000);
      axi_rd(STATUS_OFF);
      `CHK(rd[2:0], 3'(LDM_STANDBY))
      // start the oscillator, wait, then leave standby
      axi_wr(POWER_OFF, 32'h0000_0102);
      repeat (12) @(posedge aclk);
      `CHK(osc_run, 1'b1)
      axi_wr(POWER_OFF, 32'h0000_0010);
      axi_rd(STATUS_OFF);
      `CHK(rd[3:0], {1'b1, 3'(LDM_RUN)})
      `CHK({seg_gnd, com_gnd, gnd_drive_seen}, 3'b000)
      // standby entered from run with amp power off
      axi_wr(POWER_OFF, 32'h0000_0002);
      repeat (2) @(posedge aclk);
      `CHK({power_on, osc_run, seg_gnd}, 3'b001)
      final_report();
   end
endmodule
